// ===== rtl/ssr_core.sv
// Purpose: Status flags, stack pointer, reset sequencing and vectoring
// Assumes: Core pulses one-cycle events at instruction boundaries
// Notes: Registers reached over classic Wishbone, 8-bit data in low bits
// What this block does
// - Bit 7 gates every interrupt
// - Taking clears bit 7; irq return sets it
// - Bit 6 stores and loads one bit
// - Bit 4 always equals N xor V
// - Bit 5 records half-carry
// - Bit 3 records two's complement overflow
// - Bit 2 set on negative result
// - Bit 1 set on zero result
// - Bit 0 records carry
// - Status is never saved nor restored
// - 8-bit stack pointer at 0x3D
// - Push: minus one byte, minus two address
// - Pop: plus one byte, plus two address
// - Two sources, each with own enable
// - Vectors fixed at 0x000, 0x001, 0x002
// - Lower vector wins: reset, pin, timer
// - Reset from power, pin or watchdog
// - Reset clears registers, starts at 0x000
// - Fuse picks 1.1 ms or 16.0 ms
// - Fixed variant ignores the fuse
// - Taken source's flag cleared on vectoring
// - Watchdog pulse; delay starts at its fall
`timescale 1ns/1ns
`default_nettype none
`include "ssr_map.svh"

module ssr_core
    import ssr_pkg::*;
#(
    parameter bit SELECTABLE_START = 1'b1,
    parameter int unsigned SHORT_CYC = `SSR_TOUT_SHORT_CYC,
    parameter int unsigned LONG_CYC = `SSR_TOUT_LONG_CYC
) (
    // Clock, reset, enable
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    input wire logic i_ce,
    // Reset sources
    input wire logic i_por,
    input wire logic i_reset_pin_n,
    input wire logic i_wdt_expire,
    input wire logic i_fast_startup_fuse,
    // Interrupt sources
    input wire logic i_ext_pin_request,
    input wire logic i_timer_overflow_request,
    // Execution core
    input wire logic i_boundary,
    input wire logic i_irq_return_instr,
    input wire ssr_flag_upd_t i_flag_upd,
    input wire ssr_sp_op_t i_sp_op,
    // Wishbone slave
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    // Outputs to core and peripherals
    output logic o_core_reset,
    output ssr_vector_t o_vector,
    output logic o_ext_flag_clr,
    output logic o_tmr_flag_clr,
    output logic [7:0] o_flags,
    output logic [7:0] o_stack_pointer
);

    // ****************************************
    // Reset source capture
    // ****************************************
    logic por_s;
    logic pin_n_s;
    logic wdt_s;
    logic fuse_s;

    ssr_sync u_sync_por (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn),
        .i_ce(i_ce), .i_async(i_por), .o_sync(por_s));
    ssr_sync u_sync_pin (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn),
        .i_ce(i_ce), .i_async(~i_reset_pin_n), .o_sync(pin_n_s));
    ssr_sync u_sync_wdt (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn),
        .i_ce(i_ce), .i_async(i_wdt_expire), .o_sync(wdt_s));
    ssr_sync u_sync_fuse (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn),
        .i_ce(i_ce), .i_async(i_fast_startup_fuse), .o_sync(fuse_s));

    logic wdt_prev_reg;
    logic wdt_pulse;

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            wdt_prev_reg <= 1'b0;
        end else if (i_ce) begin
            wdt_prev_reg <= wdt_s;
        end
    end

    // Expiry gives a single-cycle internal reset pulse
    assign wdt_pulse = wdt_s & ~wdt_prev_reg;

    logic rst_cause;
    assign rst_cause = por_s | pin_n_s | wdt_pulse;

    // ****************************************
    // Start-up delay sequencer
    // ****************************************
    ssr_state_t state_reg;
    logic [31:0] delay_reg;
    logic [31:0] delay_len;
    logic fuse_reg;

    // Fuse is followed until its synchroniser has settled, then frozen,
    // so a flip mid-count is ignored
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            fuse_reg <= 1'b1;
        end else if (i_ce && (state_reg == SSR_ST_RESET
            || (state_reg == SSR_ST_DELAY && delay_reg < 32'h2))) begin
            fuse_reg <= fuse_s;
        end
    end

    always_comb begin
        if (!SELECTABLE_START) begin
            delay_len = LONG_CYC;
        end else if (!fuse_reg) begin
            delay_len = SHORT_CYC;
        end else begin
            delay_len = LONG_CYC;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_reg <= SSR_ST_RESET;
            delay_reg <= 32'h0;
        end else if (i_ce) begin
            if (rst_cause) begin
                state_reg <= SSR_ST_RESET;
                delay_reg <= 32'h0;
            end else begin
                case (state_reg)
                    SSR_ST_RESET: begin
                        // Count starts after the cause falls
                        state_reg <= SSR_ST_DELAY;
                        delay_reg <= 32'h0;
                    end
                    SSR_ST_DELAY: begin
                        if (delay_reg >= delay_len - 32'h1) begin
                            state_reg <= SSR_ST_RUN;
                        end else begin
                            delay_reg <= delay_reg + 32'h1;
                        end
                    end
                    SSR_ST_RUN: begin
                        state_reg <= SSR_ST_RUN;
                    end
                    default: begin
                        state_reg <= SSR_ST_RESET;
                    end
                endcase
            end
        end
    end

    logic in_reset;
    assign in_reset = (state_reg != SSR_ST_RUN);
    assign o_core_reset = in_reset;

    // ****************************************
    // Wishbone decode
    // ****************************************
    logic ack_reg;
    logic [31:0] rdat_reg;
    logic wb_req;
    logic wr_sp;
    logic wr_flags;
    logic wr_en;

    assign wb_req = i_wb_cyc & i_wb_stb & ~ack_reg;
    assign wr_sp = wb_req & i_wb_we & i_wb_sel[0]
        & (i_wb_adr == `SSR_SP_ADDR);
    assign wr_flags = wb_req & i_wb_we & i_wb_sel[0]
        & (i_wb_adr == `SSR_FLAGS_ADDR);
    assign wr_en = wb_req & i_wb_we & i_wb_sel[0]
        & (i_wb_adr == `SSR_SRC_EN_ADDR);

    // ****************************************
    // Interrupt arbitration and vectoring
    // ****************************************
    logic [1:0] src_en_reg;
    logic [7:0] flags_reg;
    logic take_ext;
    logic take_tmr;
    logic take_any;

    // Reset outranks both, pin outranks timer
    assign take_ext = ~in_reset & ~rst_cause & i_boundary
        & flags_reg[`SSR_BIT_I] & src_en_reg[`SSR_EN_EXT]
        & i_ext_pin_request;
    assign take_tmr = ~in_reset & ~rst_cause & i_boundary
        & flags_reg[`SSR_BIT_I] & src_en_reg[`SSR_EN_TMR]
        & i_timer_overflow_request & ~take_ext;
    assign take_any = take_ext | take_tmr;

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_vector <= '0;
            o_ext_flag_clr <= 1'b0;
            o_tmr_flag_clr <= 1'b0;
        end else if (i_ce) begin
            o_ext_flag_clr <= take_ext;
            o_tmr_flag_clr <= take_tmr;
            if (rst_cause || state_reg == SSR_ST_DELAY) begin
                o_vector.valid <= 1'b0;
                o_vector.addr <= `SSR_VEC_RESET;
            end else if (state_reg == SSR_ST_RESET) begin
                o_vector.valid <= 1'b0;
                o_vector.addr <= `SSR_VEC_RESET;
            end else begin
                o_vector.valid <= take_any;
                if (take_ext) begin
                    o_vector.addr <= `SSR_VEC_EXT;
                end else if (take_tmr) begin
                    o_vector.addr <= `SSR_VEC_TMR;
                end
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            src_en_reg <= `SSR_EN_RST;
        end else if (i_ce) begin
            if (in_reset) begin
                src_en_reg <= `SSR_EN_RST;
            end else if (wr_en) begin
                src_en_reg <= i_wb_dat[1:0];
            end
        end
    end

    // ****************************************
    // Status flags
    // ****************************************
    logic [7:0] flags_next;

    // Entry and return touch only bit 7; nothing else is stacked
    always_comb begin
        flags_next = flags_reg;
        if (wr_flags) begin
            flags_next = i_wb_dat[7:0];
        end
        if (i_flag_upd.mask[`SSR_BIT_T]) begin
            flags_next[`SSR_BIT_T] = i_flag_upd.t;
        end
        if (i_flag_upd.mask[`SSR_BIT_H]) begin
            flags_next[`SSR_BIT_H] = i_flag_upd.h;
        end
        if (i_flag_upd.mask[`SSR_BIT_V]) begin
            flags_next[`SSR_BIT_V] = i_flag_upd.v;
        end
        if (i_flag_upd.mask[`SSR_BIT_N]) begin
            flags_next[`SSR_BIT_N] = i_flag_upd.n;
        end
        if (i_flag_upd.mask[`SSR_BIT_Z]) begin
            flags_next[`SSR_BIT_Z] = i_flag_upd.z;
        end
        if (i_flag_upd.mask[`SSR_BIT_C]) begin
            flags_next[`SSR_BIT_C] = i_flag_upd.c;
        end
        if (i_irq_return_instr) begin
            flags_next[`SSR_BIT_I] = 1'b1;
        end
        if (take_any) begin
            flags_next[`SSR_BIT_I] = 1'b0;
        end
        flags_next[`SSR_BIT_S] = flags_next[`SSR_BIT_N]
            ^ flags_next[`SSR_BIT_V];
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            flags_reg <= `SSR_FLAGS_RST;
        end else if (i_ce) begin
            if (in_reset) begin
                flags_reg <= `SSR_FLAGS_RST;
            end else begin
                flags_reg <= flags_next;
            end
        end
    end

    assign o_flags = flags_reg;

    // ****************************************
    // Stack pointer
    // ****************************************
    logic [7:0] sp_reg;

    // Interrupt entry is an address push even if the core reports none
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            sp_reg <= `SSR_SP_RST;
        end else if (i_ce) begin
            if (in_reset) begin
                sp_reg <= `SSR_SP_RST;
            end else if (take_any) begin
                sp_reg <= sp_reg - 8'h02;
            end else if (wr_sp) begin
                sp_reg <= i_wb_dat[7:0];
            end else begin
                case (i_sp_op)
                    SSR_SP_PUSH1: sp_reg <= sp_reg - 8'h01;
                    SSR_SP_PUSH2: sp_reg <= sp_reg - 8'h02;
                    SSR_SP_POP1: sp_reg <= sp_reg + 8'h01;
                    SSR_SP_POP2: sp_reg <= sp_reg + 8'h02;
                    default: sp_reg <= sp_reg;
                endcase
            end
        end
    end

    assign o_stack_pointer = sp_reg;

    // ****************************************
    // Wishbone answer
    // ****************************************
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ack_reg <= 1'b0;
            rdat_reg <= 32'h0;
        end else if (i_ce) begin
            ack_reg <= wb_req;
            if (wb_req && !i_wb_we) begin
                case (i_wb_adr)
                    `SSR_SP_ADDR: rdat_reg <= {24'h0, sp_reg};
                    `SSR_FLAGS_ADDR: rdat_reg <= {24'h0, flags_reg};
                    `SSR_SRC_EN_ADDR: rdat_reg <= {30'h0, src_en_reg};
                    `SSR_START_ADDR: rdat_reg <= {30'h0, in_reset,
                        fuse_reg};
                    default: rdat_reg <= 32'h0;
                endcase
            end
        end
    end

    assign o_wb_ack = ack_reg;
    assign o_wb_dat = rdat_reg;

endmodule

`default_nettype wire

// ===== inc/ssr_map.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 10 MHz system clock, Wishbone byte addresses
// Notes: Definitions only
`ifndef SSR_MAP_SVH
`define SSR_MAP_SVH

// Register byte addresses on the bus
`define SSR_SP_ADDR 8'h3d
`define SSR_FLAGS_ADDR 8'h3f
`define SSR_SRC_EN_ADDR 8'h3b
`define SSR_START_ADDR 8'h38
// Status register bit positions
`define SSR_BIT_I 7
`define SSR_BIT_T 6
`define SSR_BIT_H 5
`define SSR_BIT_S 4
`define SSR_BIT_V 3
`define SSR_BIT_N 2
`define SSR_BIT_Z 1
`define SSR_BIT_C 0
// Source enable bit positions
`define SSR_EN_EXT 0
`define SSR_EN_TMR 1
// Reset values
`define SSR_FLAGS_RST 8'h00
`define SSR_SP_RST 8'h00
`define SSR_EN_RST 2'h0
// Program vectors
`define SSR_VEC_RESET 10'h000
`define SSR_VEC_EXT 10'h001
`define SSR_VEC_TMR 10'h002
// Start-up delays in microseconds and clock rate in MHz
`define SSR_CLK_MHZ 10
`define SSR_TOUT_SHORT_US 1100
`define SSR_TOUT_LONG_US 16000
`define SSR_TOUT_SHORT_CYC (`SSR_TOUT_SHORT_US * `SSR_CLK_MHZ)
`define SSR_TOUT_LONG_CYC (`SSR_TOUT_LONG_US * `SSR_CLK_MHZ)

`endif

// ===== inc/ssr_pkg.sv
// Purpose: Types shared by the status, stack and vectoring unit
// Assumes: Nothing
// Notes: Constants live in ssr_map.svh
package ssr_pkg;

    // Flag update from the execution core
    typedef struct packed {
        logic [7:0] mask;
        logic h;
        logic v;
        logic n;
        logic z;
        logic c;
        logic t;
    } ssr_flag_upd_t;

    // Stack operation requested by the core
    typedef enum logic [2:0] {
        SSR_SP_NONE,
        SSR_SP_PUSH1,
        SSR_SP_PUSH2,
        SSR_SP_POP1,
        SSR_SP_POP2
    } ssr_sp_op_t;

    // Vector handed to the core
    typedef struct packed {
        logic valid;
        logic [9:0] addr;
    } ssr_vector_t;

    typedef enum {
        SSR_ST_RESET,
        SSR_ST_DELAY,
        SSR_ST_RUN
    } ssr_state_t;

endpackage

// ===== rtl/ssr_sync.sv
// Purpose: Two flip-flop synchroniser for one level
// Assumes: Destination clock is i_sys_clk
// Notes: First stage feeds only the second
`timescale 1ns/1ns
`default_nettype none

module ssr_sync (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    input wire logic i_ce,
    // Level
    input wire logic i_async,
    output logic o_sync
);

    logic meta_reg;
    logic sync_reg;

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
        end else if (i_ce) begin
            meta_reg <= i_async;
            sync_reg <= meta_reg;
        end
    end

    assign o_sync = sync_reg;

endmodule

`default_nettype wire

// ===== tb/ssr_core_assertions.sv
// Purpose: Port checks for ssr_core
// Assumes: Bound to every ssr_core instance
// Notes: Quiet cycles have no take, bus or reset
`timescale 1ns/1ns
`default_nettype none

module ssr_core_assertions
    import ssr_pkg::*;
(
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    input wire logic i_ce,
    // Core side
    input wire logic i_boundary,
    input wire logic i_irq_return_instr,
    input wire ssr_flag_upd_t i_flag_upd,
    input wire ssr_sp_op_t i_sp_op,
    // Bus
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic o_wb_ack,
    // Results
    input wire logic o_core_reset,
    input wire ssr_vector_t o_vector,
    input wire logic o_ext_flag_clr,
    input wire logic o_tmr_flag_clr,
    input wire logic [7:0] o_flags,
    input wire logic [7:0] o_stack_pointer
);
    // ********
    // Helpers
    // ********
    logic quiet;
    logic [7:0] m;
    logic [7:0] nv;
    logic [7:0] step;
    assign quiet = i_ce && !i_boundary && !(i_wb_cyc && i_wb_stb)
        && !o_core_reset;
    // Bits 7 and 4 are never written by the core
    assign m = i_flag_upd.mask & 8'h6f;
    assign nv = {1'b0, i_flag_upd.t, i_flag_upd.h, 1'b0, i_flag_upd.v,
        i_flag_upd.n, i_flag_upd.z, i_flag_upd.c};
    always_comb begin
        case (i_sp_op)
            SSR_SP_PUSH1: step = 8'hff;
            SSR_SP_PUSH2: step = 8'hfe;
            SSR_SP_POP1: step = 8'h01;
            SSR_SP_POP2: step = 8'h02;
            default: step = 8'h00;
        endcase
    end
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rstn);

    a_take_gated: assert property (o_vector.valid |->
        $past(o_flags[7] && i_boundary) && !o_flags[7])
        else $error("take without enable or boundary");
    a_take_push: assert property (o_vector.valid |->
        o_stack_pointer == $past(o_stack_pointer) - 8'h02)
        else $error("take did not push two");
    a_status_kept: assert property (o_vector.valid &&
        $past(i_flag_upd.mask) == 8'h00 |->
        o_flags[6:0] == $past(o_flags[6:0]))
        else $error("status changed on take");
    a_clr_vector: assert property (o_vector.valid |->
        (o_ext_flag_clr ? o_vector.addr == 10'h001 :
        o_tmr_flag_clr && o_vector.addr == 10'h002))
        else $error("vector and clear disagree");
    a_clr_only: assert property ((o_ext_flag_clr ||
        o_tmr_flag_clr) == o_vector.valid)
        else $error("flag clear without vector");
    a_sign_xor: assert property (o_flags[4] ==
        (o_flags[2] ^ o_flags[3]))
        else $error("sign bit wrong");
    a_sp_step: assert property (quiet |=>
        o_stack_pointer == $past(o_stack_pointer + step))
        else $error("stack step wrong");
    a_flag_write: assert property (quiet |=>
        (o_flags & 8'h6f) == $past((o_flags & ~m | nv & m) & 8'h6f))
        else $error("flag update wrong");
    a_irq_return: assert property (quiet && i_irq_return_instr |=>
        o_flags[7])
        else $error("irq return left enable clear");
    a_reset_clean: assert property (o_core_reset &&
        $past(o_core_reset) |-> o_flags == 8'h00 &&
        o_stack_pointer == 8'h00 && !o_vector.valid)
        else $error("state not cleared in reset");
    a_wb_answer: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=>
        o_wb_ack ##1 !o_wb_ack)
        else $error("bus ack not one cycle");
endmodule

bind ssr_core ssr_core_assertions u_ssr_chk (
    .i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn),
    .i_ce(i_ce),
    .i_boundary(i_boundary),
    .i_irq_return_instr(i_irq_return_instr),
    .i_flag_upd(i_flag_upd),
    .i_sp_op(i_sp_op),
    .i_wb_cyc(i_wb_cyc),
    .i_wb_stb(i_wb_stb),
    .o_wb_ack(o_wb_ack),
    .o_core_reset(o_core_reset),
    .o_vector(o_vector),
    .o_ext_flag_clr(o_ext_flag_clr),
    .o_tmr_flag_clr(o_tmr_flag_clr),
    .o_flags(o_flags),
    .o_stack_pointer(o_stack_pointer)
);
`default_nettype wire

// ===== tb/ssr_src_model.sv
// Purpose: Source flags on the far side of ssr_core
// Assumes: Set pulses come from the bench
// Notes: A set wins over a clear in one cycle
`timescale 1ns/1ns
`default_nettype none

module ssr_src_model (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    // Raise requests
    input wire logic i_set_ext,
    input wire logic i_set_tmr,
    // Clears from the device
    input wire logic i_ext_clr,
    input wire logic i_tmr_clr,
    // Pending levels
    output logic o_ext_req,
    output logic o_tmr_req
);
    // ******
    // Flags
    // ******
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_ext_req <= 1'b0;
            o_tmr_req <= 1'b0;
        end else begin
            o_ext_req <= i_set_ext | (o_ext_req & ~i_ext_clr);
            o_tmr_req <= i_set_tmr | (o_tmr_req & ~i_tmr_clr);
        end
    end
endmodule
`default_nettype wire

// ===== tb/status_stack_reset_vectoring_tb.sv
// Purpose: Self-checking bench for ssr_core
// Assumes: Start-up counts cut to 20 and 50
// Notes: Source model holds pending requests
`timescale 1ns/1ns
`default_nettype none

module status_stack_reset_vectoring_tb import ssr_pkg::*;;
    localparam int SH = 20;
    localparam int LG = 50;
    typedef struct {
        ssr_sp_op_t op;
        logic [7:0] a;
        logic [7:0] w;
        logic [7:0] e;
    } ssr_row_t;
    logic clk = 0, rstn = 0, pin_n = 1, wdt = 0, por = 0, fuse = 1;
    logic bnd = 0, iret = 0, cyc = 0, stb = 0, we = 0, se = 0, st = 0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat;
    ssr_flag_upd_t upd = '0;
    ssr_sp_op_t spop = SSR_SP_NONE;
    logic ack, cres, eclr, tclr, ereq, treq, fcres;
    ssr_vector_t vec;
    logic [7:0] flags, sp, q;
    logic [9:0] lastv;
    int n_errors = 0, tests_run = 0, nvec = 0;
    ssr_row_t rows [10] = '{
        '{SSR_SP_NONE, 8'h3d, 8'h5a, 8'h5a},
        '{SSR_SP_PUSH1, 8'h3d, 8'hdf, 8'hde},
        '{SSR_SP_PUSH2, 8'h3d, 8'hdf, 8'hdd},
        '{SSR_SP_POP1, 8'h3d, 8'h60, 8'h61},
        '{SSR_SP_POP2, 8'h3d, 8'h60, 8'h62},
        '{SSR_SP_NONE, 8'h3f, 8'hff, 8'hef},
        '{SSR_SP_NONE, 8'h3f, 8'h00, 8'h00},
        '{SSR_SP_NONE, 8'h3b, 8'hff, 8'h03},
        '{SSR_SP_NONE, 8'h10, 8'h77, 8'h00},
        '{SSR_SP_NONE, 8'h38, 8'hff, 8'h01}
    };

    always #50 clk = ~clk;
    always @(posedge clk) begin
        if (vec.valid === 1'b1) begin
            nvec++;
            lastv = vec.addr;
        end
    end

    ssr_core #(.SHORT_CYC(SH), .LONG_CYC(LG)) DUT (
        .i_sys_clk(clk),
        .i_rstn(rstn),
        .i_ce(1'b1),
        .i_por(por),
        .i_reset_pin_n(pin_n),
        .i_wdt_expire(wdt),
        .i_fast_startup_fuse(fuse),
        .i_ext_pin_request(ereq),
        .i_timer_overflow_request(treq),
        .i_boundary(bnd),
        .i_irq_return_instr(iret),
        .i_flag_upd(upd),
        .i_sp_op(spop),
        .i_wb_cyc(cyc),
        .i_wb_stb(stb),
        .i_wb_we(we),
        .i_wb_adr(adr),
        .i_wb_sel(4'hf),
        .i_wb_dat(wdat),
        .o_wb_dat(rdat),
        .o_wb_ack(ack),
        .o_core_reset(cres),
        .o_vector(vec),
        .o_ext_flag_clr(eclr),
        .o_tmr_flag_clr(tclr),
        .o_flags(flags),
        .o_stack_pointer(sp)
    );
    // Fixed start-up variant sees the same causes and fuse
    ssr_core #(.SELECTABLE_START(1'b0), .SHORT_CYC(SH), .LONG_CYC(LG))
        DUT_FIXED (
        .i_sys_clk(clk), .i_rstn(rstn), .i_ce(1'b1),
        .i_por(por), .i_reset_pin_n(pin_n), .i_wdt_expire(wdt),
        .i_fast_startup_fuse(fuse),
        .i_ext_pin_request(1'b0), .i_timer_overflow_request(1'b0),
        .i_boundary(1'b0), .i_irq_return_instr(1'b0),
        .i_flag_upd('0), .i_sp_op(SSR_SP_NONE),
        .i_wb_cyc(1'b0), .i_wb_stb(1'b0), .i_wb_we(1'b0),
        .i_wb_adr(8'h00), .i_wb_sel(4'h0), .i_wb_dat(32'h0),
        .o_wb_dat(), .o_wb_ack(), .o_core_reset(fcres), .o_vector(),
        .o_ext_flag_clr(), .o_tmr_flag_clr(), .o_flags(),
        .o_stack_pointer()
    );
    ssr_src_model u_src (
        .i_sys_clk(clk),
        .i_rstn(rstn),
        .i_set_ext(se),
        .i_set_tmr(st),
        .i_ext_clr(eclr),
        .i_tmr_clr(tclr),
        .o_ext_req(ereq),
        .o_tmr_req(treq)
    );

    // *****
    // Tasks
    // *****
    task automatic chk(input string nm, input logic [9:0] e,
        input logic [9:0] g);
        tests_run++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic wb(input logic w, input logic [7:0] a,
        input logic [7:0] d);
        int n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h0, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        chk("bus answer", 1, ack);
        if (ack !== 1'b1) tally_and_finish;
        q = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic pulse_bnd;
        @(posedge clk);
        bnd <= 1'b1;
        @(posedge clk);
        bnd <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    task automatic core_upd(input logic [5:0] v, input logic [7:0] e);
        @(posedge clk);
        upd <= {8'h6f, v};
        @(posedge clk);
        upd <= '0;
        @(posedge clk);
        chk("core flags", e, flags);
    endtask
    task automatic run_len(input int lo, input int hi);
        int n = 0;
        while (cres !== 1'b1 && n < 8) begin
            @(posedge clk);
            n++;
        end
        n = 0;
        chk("reset vector", 10'h000, vec.addr);
        while (cres === 1'b1 && n <= hi) begin
            @(posedge clk);
            n++;
        end
        chk("start-up in range", 1, n >= lo && n <= hi);
        if (cres === 1'b1) tally_and_finish;
    endtask

    initial begin
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        run_len(LG, LG + 8);
        chk("fixed start-up", 0, fcres);
        for (int i = 0; i < 10; i++) begin
            wb(1, rows[i].a, rows[i].w);
            @(posedge clk);
            spop <= rows[i].op;
            @(posedge clk);
            spop <= SSR_SP_NONE;
            wb(0, rows[i].a, 8'h00);
            chk("register", rows[i].e, q);
        end
        core_upd(6'b101011, 8'h75);
        core_upd(6'b011100, 8'h0e);
        wb(1, 8'h3f, 8'h00);
        // Stack set high while bit 7 is clear, both sources enabled
        wb(1, 8'h3d, 8'hdf);
        @(posedge clk);
        se <= 1'b1;
        st <= 1'b1;
        @(posedge clk);
        se <= 1'b0;
        st <= 1'b0;
        pulse_bnd;
        chk("masked take", 0, nvec);
        wb(1, 8'h3f, 8'h81);
        pulse_bnd;
        chk("pin vector", 10'h001, lastv);
        chk("flags on take", 8'h01, flags);
        chk("stack on take", 8'hdd, sp);
        chk("pending", 2'b01, {ereq, treq});
        pulse_bnd;
        chk("nested take", 1, nvec);
        @(posedge clk);
        iret <= 1'b1;
        @(posedge clk);
        iret <= 1'b0;
        pulse_bnd;
        chk("timer vector", 10'h002, lastv);
        chk("pending", 2'b00, {ereq, treq});
        wb(1, 8'h3b, 8'h01);
        wb(1, 8'h3f, 8'h80);
        @(posedge clk);
        st <= 1'b1;
        @(posedge clk);
        st <= 1'b0;
        pulse_bnd;
        chk("source disabled", 2, nvec);
        for (int k = 0; k < 3; k++) begin
            @(posedge clk);
            fuse <= k[0];
            por <= (k == 0);
            pin_n <= (k != 1);
            wdt <= (k == 2);
            repeat (3) @(posedge clk);
            por <= 1'b0;
            pin_n <= 1'b1;
            wdt <= 1'b0;
            run_len((k[0] ? LG : SH) - 2, (k[0] ? LG : SH) + 8);
            if (k == 0) chk("fixed start-up", 1, fcres);
            wb(0, 8'h38, 8'h00);
            chk("fuse latch", {7'h0, k[0]}, q);
            wb(0, 8'h3d, 8'h00);
            chk("stack after reset", 0, q);
        end
        tally_and_finish;
    end
endmodule
`default_nettype wire
